// >>> common/rsg_pkg.sv
// Constants, types and helpers for the reset, strap and general pin block.
// Assumes one 50 MHz bus clock and an AHB-Lite register port with 32-bit data.
package rsg_pkg;
  localparam logic [7:0] ADDR_STRAP = 8'h00;
  localparam logic [7:0] ADDR_FUNC = 8'h04;
  localparam logic [7:0] ADDR_OUT = 8'h08;
  localparam logic [7:0] ADDR_IN = 8'h0c;
  localparam int NPINS = 9;
  localparam int PIN_STAT_A = 0;
  localparam int PIN_STAT_B = 1;
  localparam int PIN_GEN_A = 2;
  localparam int PIN_SHARED_LO = 5;
  localparam int STRAP_A_BIT = 8;
  localparam int STRAP_B_BIT = 9;
  localparam int REFSEL_LSB = 10;
  localparam int CAPTURED_BIT = 12;
  localparam int RXD_REFSEL_LSB = 2;
  localparam logic [17:0] FUNC_RESET = 18'h00000;
  localparam logic [8:0] OUT_RESET = 9'h000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [2:0] {MODE_GMII, MODE_RGMII, MODE_TEN_BIT_INTERFACE, MODE_REDUCED_TEN_BIT, MODE_MII} rsg_mode_t;
  typedef enum logic [1:0] {FUNC_DEFAULT, FUNC_HIZ, FUNC_DRIVE, FUNC_CLOCK} rsg_func_t;
  typedef enum logic [1:0] {REF_10M, REF_12M8, REF_25M, REF_125M} rsg_ref_clock_t;

  function automatic logic is_ten_bit(input logic [2:0] m);
    is_ten_bit = (m == 3'(MODE_TEN_BIT_INTERFACE)) || (m == 3'(MODE_REDUCED_TEN_BIT));
  endfunction : is_ten_bit

  function automatic logic shared_allowed(input logic [2:0] m);
    shared_allowed = (m == 3'(MODE_MII)) || (m == 3'(MODE_RGMII)) || (m == 3'(MODE_REDUCED_TEN_BIT));
  endfunction : shared_allowed
endpackage : rsg_pkg

// >>> common/rsg_strap_if.sv
// Carries captured strap levels from the capture module to the top.
// Assumes both ends run on the bus clock.
`timescale 1ns/100ps
interface rsg_strap_if;
  logic captured;
  logic [7:0] strap_rxd;
  logic strap_a;
  logic strap_b;
  modport capture (output captured, output strap_rxd, output strap_a, output strap_b);
  modport user (input captured, input strap_rxd, input strap_a, input strap_b);
endinterface : rsg_strap_if

// >>> logic/rsg_strap_capture.sv
// Catches strap pin levels just after reset release.
// Assumes the pads stay undriven by this block until captured goes high.
`timescale 1ns/100ps
module rsg_strap_capture (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] rxd_in,
  input wire logic status_output_a_in,
  input wire logic status_output_b_in,
  rsg_strap_if.capture straps
);
  typedef enum {CAP_SYNC1, CAP_SYNC2, CAP_DONE} rsg_cap_t;
  rsg_cap_t state;
  rsg_cap_t next_state;
  logic [7:0] next_rxd;
  logic next_a;
  logic next_b;

  // One edge of settling after release, then capture on the second
  always_comb begin
    next_state = state;
    next_rxd = straps.strap_rxd;
    next_a = straps.strap_a;
    next_b = straps.strap_b;
    case (state)
      CAP_SYNC1: next_state = CAP_SYNC2;
      CAP_SYNC2: begin
        next_state = CAP_DONE;
        next_rxd = rxd_in;
        next_a = status_output_a_in;
        next_b = status_output_b_in;
      end
      CAP_DONE: next_state = CAP_DONE;
      default: next_state = CAP_SYNC1;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CAP_SYNC1;
      straps.strap_rxd <= 8'h00;
      straps.strap_a <= 1'b0;
      straps.strap_b <= 1'b0;
      straps.captured <= 1'b0;
    end else begin
      state <= next_state;
      straps.strap_rxd <= next_rxd;
      straps.strap_a <= next_a;
      straps.strap_b <= next_b;
      straps.captured <= (next_state == CAP_DONE);
    end
  end
endmodule : rsg_strap_capture

// >>> logic/rsg_top.sv
// Reset, strap capture and general pin control with an AHB-Lite register port.
// Assumes pads resolve in/out/oe outside; parallel_mode comes from the mode logic.
// Function
// - Reset clears all state asynchronously
// - Strap levels become register defaults
// - Receive data bits 3:2 select reference clock
// - Status pins are straps, then configured outputs
// - Status A: high-Z in ten-bit, else link
// - Status B: high-Z in ten-bit, else carrier
// - Status A strapped low: pin A high-Z
// - Status A strapped high: pin A clocks
// - Software may reassign every status and general pin function
// - Pins B and C start high impedance
// - Shared pins only in MII/RGMII/reduced ten-bit modes
// - Receive data pins driven after reset
`timescale 1ns/100ps
module rsg_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] parallel_mode,
  input wire logic link_up,
  input wire logic carrier_sense,
  input wire logic clock_125_in,
  input wire logic [7:0] rx_data_path,
  input wire logic [7:0] rxd_in,
  output logic [7:0] rxd_out,
  output logic [7:0] rxd_oe,
  output logic [1:0] ref_clock_select,
  output logic strap_done,
  input wire logic status_output_a_in,
  output logic status_output_a_out,
  output logic status_output_a_oe,
  input wire logic status_output_b_in,
  output logic status_output_b_out,
  output logic status_output_b_oe,
  input wire logic general_pin_a_in,
  output logic general_pin_a_out,
  output logic general_pin_a_oe,
  input wire logic general_pin_b_in,
  output logic general_pin_b_out,
  output logic general_pin_b_oe,
  input wire logic general_pin_c_in,
  output logic general_pin_c_out,
  output logic general_pin_c_oe,
  input wire logic [3:0] general_pin_shared_tx_in,
  output logic [3:0] general_pin_shared_tx_out,
  output logic [3:0] general_pin_shared_tx_oe
);
  rsg_strap_if straps ();

  rsg_strap_capture u_capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .rxd_in(rxd_in),
    .status_output_a_in(status_output_a_in),
    .status_output_b_in(status_output_b_in),
    .straps(straps)
  );

  logic [17:0] pin_func;
  logic [8:0] pin_out_reg;
  logic [8:0] pin_in_reg;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [17:0] next_pin_func;
  logic [8:0] next_pin_out_reg;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [8:0] pin_val;
  logic [8:0] pin_oe;
  logic [8:0] pin_clk;
  logic [8:0] next_pin_val;
  logic [8:0] next_pin_oe;
  logic [8:0] next_pin_clk;
  logic [7:0] next_rxd_out;
  logic [7:0] next_rxd_oe;
  logic [8:0] pin_in_now;
  logic addr_ok;
  logic [31:0] strap_word;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && (htrans == rsg_pkg::HTRANS_NONSEQ);
  assign pin_in_now = {general_pin_shared_tx_in, general_pin_c_in, general_pin_b_in, general_pin_a_in,
                       status_output_b_in, status_output_a_in};
  assign ref_clock_select = straps.strap_rxd[rsg_pkg::RXD_REFSEL_LSB +: 2];
  assign strap_done = straps.captured;

  always_comb begin
    strap_word = 32'h00000000;
    strap_word[7:0] = straps.strap_rxd;
    strap_word[rsg_pkg::STRAP_A_BIT] = straps.strap_a;
    strap_word[rsg_pkg::STRAP_B_BIT] = straps.strap_b;
    strap_word[rsg_pkg::REFSEL_LSB +: 2] = ref_clock_select;
    strap_word[rsg_pkg::CAPTURED_BIT] = straps.captured;
  end

  // Register port: writes land in the data phase, reads are taken in the address phase
  always_comb begin
    next_pin_func = pin_func;
    next_pin_out_reg = pin_out_reg;
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = haddr[7:0];
    next_hrdata = hrdata;
    if (wr_pend) begin
      case (wr_addr)
        rsg_pkg::ADDR_FUNC: next_pin_func = hwdata[17:0];
        rsg_pkg::ADDR_OUT: next_pin_out_reg = hwdata[8:0];
        default: next_pin_func = pin_func;
      endcase
    end
    if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        rsg_pkg::ADDR_STRAP: next_hrdata = strap_word;
        rsg_pkg::ADDR_FUNC: next_hrdata = {14'h0000, next_pin_func};
        rsg_pkg::ADDR_OUT: next_hrdata = {23'h000000, next_pin_out_reg};
        rsg_pkg::ADDR_IN: next_hrdata = {23'h000000, pin_in_reg};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  // Pin function resolution
  always_comb begin
    next_pin_val = 9'h000;
    next_pin_oe = 9'h000;
    next_pin_clk = 9'h000;
    for (int i = 0; i < rsg_pkg::NPINS; i++) begin
      case (rsg_pkg::rsg_func_t'(pin_func[2*i +: 2]))
        rsg_pkg::FUNC_DEFAULT: begin
          if (i == rsg_pkg::PIN_STAT_A) begin
            next_pin_oe[i] = !rsg_pkg::is_ten_bit(parallel_mode);
            next_pin_val[i] = link_up;
          end else if (i == rsg_pkg::PIN_STAT_B) begin
            next_pin_oe[i] = !rsg_pkg::is_ten_bit(parallel_mode);
            next_pin_val[i] = carrier_sense;
          end else if (i == rsg_pkg::PIN_GEN_A) begin
            next_pin_oe[i] = straps.strap_a;
            next_pin_clk[i] = straps.strap_a;
          end else begin
            next_pin_oe[i] = 1'b0;
          end
        end
        rsg_pkg::FUNC_HIZ: next_pin_oe[i] = 1'b0;
        rsg_pkg::FUNC_DRIVE: begin
          next_pin_oe[i] = 1'b1;
          next_pin_val[i] = pin_out_reg[i];
        end
        rsg_pkg::FUNC_CLOCK: begin
          next_pin_oe[i] = 1'b1;
          next_pin_clk[i] = 1'b1;
        end
        default: next_pin_oe[i] = 1'b0;
      endcase
      if (i >= rsg_pkg::PIN_SHARED_LO && !rsg_pkg::shared_allowed(parallel_mode)) begin
        next_pin_oe[i] = 1'b0;
        next_pin_clk[i] = 1'b0;
      end
      if (!straps.captured) begin
        next_pin_oe[i] = 1'b0;
        next_pin_clk[i] = 1'b0;
      end
    end
    next_rxd_oe = straps.captured ? 8'hff : 8'h00;
    next_rxd_out = rx_data_path;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_func <= rsg_pkg::FUNC_RESET;
      pin_out_reg <= rsg_pkg::OUT_RESET;
      pin_in_reg <= 9'h000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      pin_val <= 9'h000;
      pin_oe <= 9'h000;
      pin_clk <= 9'h000;
      rxd_out <= 8'h00;
      rxd_oe <= 8'h00;
    end else begin
      pin_func <= next_pin_func;
      pin_out_reg <= next_pin_out_reg;
      pin_in_reg <= pin_in_now;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      pin_val <= next_pin_val;
      pin_oe <= next_pin_oe;
      pin_clk <= next_pin_clk;
      rxd_out <= next_rxd_out;
      rxd_oe <= next_rxd_oe;
    end
  end

  // The 125 MHz clock is faster than hclk, so it is gated onto the pad, not registered
  always_comb begin
    status_output_a_out = pin_clk[0] ? clock_125_in : pin_val[0];
    status_output_b_out = pin_clk[1] ? clock_125_in : pin_val[1];
    general_pin_a_out = pin_clk[2] ? clock_125_in : pin_val[2];
    general_pin_b_out = pin_clk[3] ? clock_125_in : pin_val[3];
    general_pin_c_out = pin_clk[4] ? clock_125_in : pin_val[4];
    for (int k = 0; k < 4; k++) begin
      general_pin_shared_tx_out[k] = pin_clk[5 + k] ? clock_125_in : pin_val[5 + k];
    end
  end

  assign status_output_a_oe = pin_oe[0];
  assign status_output_b_oe = pin_oe[1];
  assign general_pin_a_oe = pin_oe[2];
  assign general_pin_b_oe = pin_oe[3];
  assign general_pin_c_oe = pin_oe[4];
  assign general_pin_shared_tx_oe = pin_oe[8:5];
endmodule : rsg_top

// >>> verif/rsg_assertions.sv
// Checker for rsg_top pin defaults and strap capture.
// Sees only rsg_top ports; bound at the foot of this file.
`timescale 1ns/100ps
module rsg_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [2:0] parallel_mode,
  input wire logic [7:0] rxd_in,
  input wire logic [7:0] rxd_oe,
  input wire logic [1:0] ref_clock_select,
  input wire logic strap_done,
  input wire logic status_output_a_in,
  input wire logic status_output_a_oe,
  input wire logic status_output_b_oe,
  input wire logic general_pin_a_oe,
  input wire logic general_pin_b_oe,
  input wire logic general_pin_c_oe,
  input wire logic [3:0] general_pin_shared_tx_oe
);
  logic sw;
  logic next_sw;
  logic strap_a;
  logic next_strap_a;
  // Defaults hold only until software writes the function register
  always_comb begin
    next_sw = sw | (hsel & hready & hwrite & htrans == rsg_pkg::HTRANS_NONSEQ & haddr[7:0] == rsg_pkg::ADDR_FUNC);
    next_strap_a = strap_done ? strap_a : status_output_a_in;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw <= 1'b0;
      strap_a <= 1'b0;
    end else begin
      sw <= next_sw;
      strap_a <= next_strap_a;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_quiet; !strap_done |-> rxd_oe == 8'h00 && !general_pin_a_oe && !status_output_a_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("pin driven before straps taken");
  property p_refsel; $rose(strap_done) |-> ref_clock_select == rxd_in[3:2]; endproperty
  a_refsel: assert property (p_refsel) else $error("clock select differs from strap");
  property p_rxd; $rose(strap_done) |=> rxd_oe == 8'hff; endproperty
  a_rxd: assert property (p_rxd) else $error("receive pins not driven");
  property p_stat_a; $past(strap_done) && !sw && !($past(parallel_mode) inside {3'h2, 3'h3}) |-> status_output_a_oe; endproperty
  a_stat_a: assert property (p_stat_a) else $error("status a not driven");
  property p_stat_b; $past(strap_done) && !sw && $past(parallel_mode) inside {3'h2, 3'h3} |-> !status_output_b_oe; endproperty
  a_stat_b: assert property (p_stat_b) else $error("status b driven in ten-bit");
  property p_gen_a; $past(strap_done) && !sw |-> general_pin_a_oe == strap_a; endproperty
  a_gen_a: assert property (p_gen_a) else $error("general a default wrong");
  property p_gen_bc; $past(strap_done) && !sw |-> !general_pin_b_oe && !general_pin_c_oe; endproperty
  a_gen_bc: assert property (p_gen_bc) else $error("general b or c driven");
  property p_shared; $past(strap_done) && !($past(parallel_mode) inside {3'h1, 3'h3, 3'h4}) |-> general_pin_shared_tx_oe == 4'h0; endproperty
  a_shared: assert property (p_shared) else $error("shared pin driven");
endmodule : rsg_checker
bind rsg_top rsg_checker u_rsg_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .parallel_mode(parallel_mode), .rxd_in(rxd_in),
  .rxd_oe(rxd_oe), .ref_clock_select(ref_clock_select), .strap_done(strap_done),
  .status_output_a_in(status_output_a_in), .status_output_a_oe(status_output_a_oe),
  .status_output_b_oe(status_output_b_oe), .general_pin_a_oe(general_pin_a_oe),
  .general_pin_b_oe(general_pin_b_oe), .general_pin_c_oe(general_pin_c_oe),
  .general_pin_shared_tx_oe(general_pin_shared_tx_oe));

// >>> verif/rsg_board_model.sv
// Board side: strap resistors and pad resolution.
// Pin order: rxd[7:0], status a, b, general a, b, c, tx4..tx7.
`timescale 1ns/100ps
module rsg_board_model (
  input wire logic [16:0] pull,
  input wire logic [16:0] drv,
  input wire logic [16:0] oe,
  output logic [16:0] pad
);
  // A released pad settles to its strap resistor level
  always_comb begin
    for (int i = 0; i < 17; i++) begin
      pad[i] = oe[i] ? drv[i] : pull[i];
    end
  end
endmodule : rsg_board_model

// >>> verif/rsg_top_tb.sv
// Testbench for rsg_top: strap defaults and software pin control.
// Assumes the board model resolves every pad.
`timescale 1ns/100ps
module rsg_top_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [2:0] parallel_mode = 3'h0;
  logic link_up = 1'b1;
  logic carrier_sense = 1'b1;
  logic clock_125_in = 1'b0;
  logic [7:0] rx_data_path = 8'h00;
  logic [7:0] srxd = 8'h00;
  logic sa = 1'b0;
  logic sb = 1'b0;
  logic [31:0] rd;
  int err_total = 0;
  int n_compared = 0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, strap_done;
  logic [7:0] rxd_out, rxd_oe, rxd_in;
  logic [1:0] ref_clock_select;
  logic status_output_a_out, status_output_a_oe, status_output_a_in;
  logic status_output_b_out, status_output_b_oe, status_output_b_in;
  logic general_pin_a_in, general_pin_a_out, general_pin_a_oe, general_pin_b_in, general_pin_b_out;
  logic general_pin_b_oe, general_pin_c_in, general_pin_c_out, general_pin_c_oe;
  logic [3:0] general_pin_shared_tx_in, general_pin_shared_tx_out, general_pin_shared_tx_oe;
  logic [16:0] pad, po, oe;
  wire logic hready = hreadyout;
  rsg_top u_rsg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .parallel_mode(parallel_mode), .link_up(link_up), .carrier_sense(carrier_sense), .clock_125_in(clock_125_in),
    .rx_data_path(rx_data_path), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .ref_clock_select(ref_clock_select), .strap_done(strap_done),
    .status_output_a_in(status_output_a_in), .status_output_a_out(status_output_a_out),
    .status_output_a_oe(status_output_a_oe), .status_output_b_in(status_output_b_in),
    .status_output_b_out(status_output_b_out), .status_output_b_oe(status_output_b_oe),
    .general_pin_a_in(general_pin_a_in), .general_pin_a_out(general_pin_a_out), .general_pin_a_oe(general_pin_a_oe),
    .general_pin_b_in(general_pin_b_in), .general_pin_b_out(general_pin_b_out), .general_pin_b_oe(general_pin_b_oe),
    .general_pin_c_in(general_pin_c_in), .general_pin_c_out(general_pin_c_out), .general_pin_c_oe(general_pin_c_oe),
    .general_pin_shared_tx_in(general_pin_shared_tx_in), .general_pin_shared_tx_out(general_pin_shared_tx_out),
    .general_pin_shared_tx_oe(general_pin_shared_tx_oe));
  rsg_board_model u_rsg_board_model (.pull({7'h00, sb, sa, srxd}), .drv(po), .oe(oe), .pad(pad));
  assign oe = {general_pin_shared_tx_oe, general_pin_c_oe, general_pin_b_oe, general_pin_a_oe,
    status_output_b_oe, status_output_a_oe, rxd_oe};
  assign po = {general_pin_shared_tx_out, general_pin_c_out, general_pin_b_out, general_pin_a_out,
    status_output_b_out, status_output_a_out, rxd_out};
  assign {general_pin_shared_tx_in, general_pin_c_in, general_pin_b_in, general_pin_a_in,
    status_output_b_in, status_output_a_in, rxd_in} = pad;
  initial forever #10 hclk = ~hclk;
  initial forever #4 clock_125_in = ~clock_125_in;

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= rsg_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic reboot(input logic [1:0] k);
    hresetn <= 1'b0;
    srxd <= {4'h5, k, 2'h1};
    sa <= k[0];
    sb <= ~k[0];
    parallel_mode <= {1'b0, k};
    rx_data_path <= {k, 6'h2a};
    // Status levels chosen opposite to the strap pulls so a driven pad is told apart
    link_up <= ~k[0];
    carrier_sense <= k[0];
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    while (strap_done !== 1'b1) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask : reboot

  // Each pass resets with new straps and mode, then takes the pins over
  initial begin
    @(posedge hclk);
    for (int k = 0; k < 4; k++) begin
      reboot(2'(k));
      bus(1'b0, rsg_pkg::ADDR_STRAP, 32'h0);
      chk("strap reg", {19'h0, 1'b1, srxd[3:2], sb, sa, srxd}, rd);
      chk("refsel", {30'h0, srxd[3:2]}, {30'h0, ref_clock_select});
      chk("default oe", {19'h0, 2'h0, sa, ~srxd[3], ~srxd[3], 8'hff}, {19'h0, oe[12:0]});
      chk("status pads", {30'h0, srxd[3] ? {sb, sa} : {carrier_sense, link_up}}, {30'h0, pad[9:8]});
      chk("bus status", 32'h1, {30'h0, hresp, hreadyout});
      // One edge apart the forwarded clock shows both levels
      repeat (2) begin
        chk("gen a pad", {31'h0, sa & clock_125_in}, {31'h0, pad[10]});
        @(posedge hclk);
      end
      chk("rxd out", {24'h0, rx_data_path}, {24'h0, rxd_out});
      bus(1'b0, rsg_pkg::ADDR_FUNC, 32'h0);
      chk("func reset", 32'h0, rd);
      parallel_mode <= 3'h4;
      bus(1'b1, rsg_pkg::ADDR_FUNC, 32'h0002aaaa);
      bus(1'b1, rsg_pkg::ADDR_OUT, 32'h000001a5);
      repeat (2) @(posedge hclk);
      chk("sw oe", 32'h1ff, {23'h0, oe[16:8]});
      chk("sw out", 32'h1a5, {23'h0, po[16:8]});
      bus(1'b0, rsg_pkg::ADDR_IN, 32'h0);
      chk("in reg", 32'h1a5, rd);
      bus(1'b0, rsg_pkg::ADDR_FUNC, 32'h0);
      chk("func", 32'h0002aaaa, rd);
      // Status A released, status B forwards the clock
      bus(1'b1, rsg_pkg::ADDR_FUNC, 32'h0002aaad);
      repeat (2) @(posedge hclk);
      chk("hiz and clock oe", 32'h2, {30'h0, oe[9:8]});
      repeat (2) begin
        chk("clock out", {31'h0, clock_125_in}, {31'h0, pad[9]});
        @(posedge hclk);
      end
      parallel_mode <= 3'h2;
      repeat (2) @(posedge hclk);
      chk("ten-bit shared", 32'h0, {28'h0, general_pin_shared_tx_oe});
      bus(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("pass %0d done", k);
    end
    print_verdict();
  end

  // Four passes take a few microseconds; this bounds a hang
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule : rsg_top_tb
